/* ltc_pkg.sv */
// Package: constants and types for the teach and mode controller
package ltc_pkg;
  // ============================================================
  // Register map
  localparam logic [7:0] LTC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] LTC_ADDR_CMD = 8'h04;
  localparam logic [7:0] LTC_ADDR_STATUS = 8'h08;
  localparam logic [7:0] LTC_ADDR_COUNT = 8'h0c;
  localparam logic [7:0] LTC_ADDR_LEVELS = 8'h10;
  localparam logic [7:0] LTC_ADDR_BLANK = 8'h14;
  // CTRL fields
  localparam int LTC_CTRL_RES_LO = 0;
  localparam int LTC_CTRL_NVM = 2;
  localparam int LTC_CTRL_POL_NPN = 3;
  localparam int LTC_CTRL_LINE_EN = 4;
  localparam int LTC_CTRL_AREAS_LO = 5;
  // CMD fields
  localparam int LTC_CMD_TEACH = 0;
  localparam int LTC_CMD_MEASURE = 1;
  localparam int LTC_CMD_ALIGN = 2;
  localparam logic [31:0] LTC_RD_ZERO = 32'h0000_0000;
  localparam logic [2:0] LTC_MAX_AREAS = 3'h4;
  localparam logic [1:0] LTC_BLANK_MARGIN = 2'h1;

  // ============================================================
  // Timing
  localparam int LTC_CLK_HZ = 100_000_000;
  localparam int LTC_PULSE_MIN_MS = 20;
  localparam int LTC_PULSE_MAX_MS = 80;
  localparam int LTC_PULSE_MIN_CYC = LTC_PULSE_MIN_MS * (LTC_CLK_HZ / 1000);
  localparam int LTC_PULSE_MAX_CYC = LTC_PULSE_MAX_MS * (LTC_CLK_HZ / 1000);

  typedef enum logic [1:0] {
    LTC_RES_HIGH = 2'h0,
    LTC_RES_MEDIUM = 2'h1,
    LTC_RES_LOW = 2'h2,
    LTC_RES_TRANSP = 2'h3
  } ltc_reserve_t;

  localparam logic [7:0] LTC_CTRL_RESET = 8'h04;
  localparam logic [7:0] LTC_LEVEL_MAX = 8'hff;
  localparam logic [7:0] LTC_LEVEL_NONE = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ltc_bus_req_t;

  typedef struct packed {
    logic waiting;
    logic teach_ok;
    logic teach_err;
    logic measure_mode;
  } ltc_status_t;
endpackage : ltc_pkg

/* ltc_plc_model.sv */
// Behavioural controller output driving the teach line
module ltc_plc_model (
  input wire logic clk_sys,
  input wire logic npn,
  output logic teach_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act = 1'b0;
  // Idle sits at the inactive level of the chosen polarity
  assign teach_line = act ^ npn;
  task automatic pulse(input int len);
    @(posedge clk_sys);
    act <= 1'b1;
    repeat (len) @(posedge clk_sys);
    act <= 1'b0;
  endtask : pulse
endmodule : ltc_plc_model

/* ltc_pulse_qual.sv */
// Teach line pulse qualifier with polarity and length window
module ltc_pulse_qual #(
  parameter int MIN_CYC = ltc_pkg::LTC_PULSE_MIN_CYC,
  parameter int MAX_CYC = ltc_pkg::LTC_PULSE_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic line_in,
  input wire logic npn_sel,
  input wire logic enable,
  output logic pulse_ok
);
  import ltc_pkg::*;
  localparam int CW = $clog2(MAX_CYC + 1);
  logic active;
  logic active_reg;
  logic [CW-1:0] len_reg;

  assign active = enable & (line_in ^ npn_sel); // R3

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= active;
    end
  end

  // Counter saturates so an overlong pulse cannot wrap into the window
  always_ff @(posedge clk_sys) begin
    if (srst || !active) begin
      len_reg <= '0;
    end else if (len_reg != CW'(MAX_CYC)) begin
      len_reg <= len_reg + 1'b1;
    end
  end

  // Judged on the trailing edge; outside the window nothing happens
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pulse_ok <= 1'b0;
    end else begin
      pulse_ok <= active_reg && !active && (len_reg > CW'(MIN_CYC)) &&
                  (len_reg < CW'(MAX_CYC)); // R1 R2
    end
  end
endmodule : ltc_pulse_qual

/* ltc_teach_checker.sv */
// Port assertions for the teach and mode controller
module ltc_teach_checker
  import ltc_pkg::*;
#(
  parameter int BEAMS = 32
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire ltc_pkg::ltc_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic panel_teach,
  input wire logic fieldbus_teach,
  input wire logic config_teach,
  input wire logic teach_line,
  input wire logic [BEAMS-1:0] beam_blocked,
  input wire logic [BEAMS-1:0] beam_in_corridor,
  input wire logic [3:0] line_states,
  input wire logic [BEAMS-1:0] beam_suppress,
  input wire logic [1:0] reserve_out,
  input wire logic regulate_strobe,
  input wire logic store_nvm,
  input wire logic store_volatile,
  input wire logic measure_mode,
  input wire logic waiting,
  input wire logic teach_err,
  input wire logic [7:0] first_beam_level,
  input wire logic [7:0] last_beam_level,
  input wire logic [7:0] interrupted_beam_count,
  input wire logic [3:0] configurable_lines
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // ============================================================
  // Teach outcome and mode
  chk_ok_levels: assert property (regulate_strobe |-> ##[0:1]
    (first_beam_level == 8'hff && last_beam_level == 8'hff))
    else $error("levels low after success");
  chk_err_levels: assert property ($rose(teach_err) |-> ##[0:1]
    (first_beam_level == 8'h00 && last_beam_level == 8'h00))
    else $error("levels shown after error");
  chk_ok_no_err: assert property (
    regulate_strobe |-> ##[0:1] !teach_err) else $error("error on success");
  chk_store_pair: assert property (
    (store_nvm || store_volatile) |-> regulate_strobe
    && !(store_nvm && store_volatile)) else $error("bad store pulse");
  chk_wait_len: assert property (
    $rose(waiting) |=> waiting ##1 !waiting) else $error("wait length");
  chk_result_wait: assert property (
    $rose(regulate_strobe) |-> $past(waiting)) else $error("no wait");
  chk_mode_cmd: assert property ($changed(measure_mode) |->
    $past(bus_req.wr) && $past(bus_req.addr) == LTC_ADDR_CMD)
    else $error("mode moved without command");
  chk_count_hold: assert property (
    !measure_mode && !$past(measure_mode)
    |-> $stable(interrupted_beam_count)) else $error("count moved");
  cover property (regulate_strobe && measure_mode);
  cover property ($rose(teach_err));
  cover property (store_volatile);
endmodule : ltc_teach_checker

bind ltc_teach_ctrl ltc_teach_checker #(.BEAMS(BEAMS)) i_ltc_teach_checker (.*);

/* ltc_teach_ctrl.sv */
// Operating mode and teach sequencer for the light curtain receiver
// Behaviour
// [R1] Teach line pulse counts only if longer than 20 ms, shorter than 80 ms.
// [R2] Pulses outside the window are ignored without teach or error.
// [R3] Teach line active level follows configured PNP or NPN polarity.
// [R4] Teach accepted from panel, teach line, fieldbus or configuration port.
// [R5] Performance reserve has four levels: high, medium, low, transparent.
// [R6] Performance reserve resets to high.
// [R7] Teach checks every beam is in corridor and regulates them to reserve.
// [R8] Option chooses permanent or temporary storage; permanent by default.
// [R9] Teach accepted in both measurement and alignment operation.
// [R10] Mode commands switch between measurement and alignment operation.
// [R11] After reset the device is in alignment operation.
// [R12] Measurement reports interrupted beam count and four line states.
// [R13] Without blanking areas, any interrupted beam gives a teach error.
// [R14] With blanking, interrupted beams are suppressed plus a margin.
// [R15] At most four blanking areas of adjacent beams.
// [R16] At most half of the beams may be suppressed.
// [R17] Waiting shown during teach; then return to starting operation.
// [R18] Successful teach sets both end beam levels to maximum.
// [R19] Failed teach reports no level for either end beam and an error.
// [R20] Operator requests teach only once aligned to minimum level.
// [R21] Operator re-teaches after reserve or scanning mode change.
module ltc_teach_ctrl #(
  parameter int BEAMS = 32,
  parameter int MIN_CYC = ltc_pkg::LTC_PULSE_MIN_CYC,
  parameter int MAX_CYC = ltc_pkg::LTC_PULSE_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire ltc_pkg::ltc_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire logic panel_teach,
  input wire logic fieldbus_teach,
  input wire logic config_teach,
  input wire logic teach_line,
  input wire logic [BEAMS-1:0] beam_blocked,
  input wire logic [BEAMS-1:0] beam_in_corridor,
  input wire logic [3:0] line_states,
  output logic [BEAMS-1:0] beam_suppress,
  output logic [1:0] reserve_out,
  output logic regulate_strobe,
  output logic store_nvm,
  output logic store_volatile,
  output logic measure_mode,
  output logic waiting,
  output logic teach_err,
  output logic [7:0] first_beam_level,
  output logic [7:0] last_beam_level,
  output logic [7:0] interrupted_beam_count,
  output logic [3:0] configurable_lines
);
  import ltc_pkg::*;
  localparam int BW = $clog2(BEAMS + 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CHECK = 3'b010,
    ST_DONE = 3'b100
  } ltc_state_t;

  // ============================================================
  // Helper functions
  function automatic logic [BW-1:0] pop(input logic [BEAMS-1:0] v);
    logic [BW-1:0] n;
    n = '0;
    for (int i = 0; i < BEAMS; i++) begin
      n = n + BW'(v[i]);
    end
    return n;
  endfunction : pop

  // Counts leading edges of runs; shifting avoids indexing below bit 0
  function automatic logic [BW-1:0] runs(input logic [BEAMS-1:0] v);
    return pop(v & ~(v << 1));
  endfunction : runs

  // ============================================================
  // Registers
  logic [7:0] ctrl_reg;
  ltc_state_t state_reg;
  logic line_pulse;
  logic teach_req;
  logic [BEAMS-1:0] widened;
  logic [BEAMS-1:0] widened_next;
  logic blank_fail;
  logic [2:0] areas;

  assign areas = ctrl_reg[LTC_CTRL_AREAS_LO +: 3];

  ltc_pulse_qual #(
    .MIN_CYC(MIN_CYC),
    .MAX_CYC(MAX_CYC)
  ) u_pulse (
    .clk_sys(clk_sys),
    .srst(srst),
    .line_in(teach_line),
    .npn_sel(ctrl_reg[LTC_CTRL_POL_NPN]),
    .enable(ctrl_reg[LTC_CTRL_LINE_EN]),
    .pulse_ok(line_pulse)
  );

  logic cmd_wr;
  assign cmd_wr = bus_req.wr && bus_req.addr == LTC_ADDR_CMD;
  assign teach_req = panel_teach | line_pulse | fieldbus_teach | config_teach |
                     (cmd_wr && bus_req.wdata[LTC_CMD_TEACH]); // R4

  // Blocked beams grown by the margin on both sides
  always_comb begin
    widened_next = beam_blocked;
    for (int d = 1; d <= int'(LTC_BLANK_MARGIN); d++) begin
      widened_next = widened_next | (beam_blocked << d) |
                     (beam_blocked >> d);
    end
  end
  assign widened = widened_next; // R14

  assign blank_fail = (runs(widened) > BW'(areas)) ||
                      (runs(widened) > BW'(LTC_MAX_AREAS)) || // R15
                      (pop(widened) > BW'(BEAMS / 2)); // R16

  // ============================================================
  // Control register, reset to high reserve and permanent storage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_reg <= LTC_CTRL_RESET; // R6 R8
    end else if (bus_req.wr && bus_req.addr == LTC_ADDR_CTRL) begin
      ctrl_reg <= bus_req.wdata[7:0]; // R5
    end
  end

  // ============================================================
  // Mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      measure_mode <= 1'b0; // R11
    end else if (cmd_wr && state_reg == ST_IDLE) begin
      if (bus_req.wdata[LTC_CMD_MEASURE]) begin
        measure_mode <= 1'b1; // R10
      end else if (bus_req.wdata[LTC_CMD_ALIGN]) begin
        measure_mode <= 1'b0; // R10
      end
    end
  end

  // ============================================================
  // Teach sequencer; mode is untouched so it resumes afterwards
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      waiting <= 1'b0;
      teach_err <= 1'b0;
      regulate_strobe <= 1'b0;
      store_nvm <= 1'b0;
      store_volatile <= 1'b0;
      beam_suppress <= '0;
      reserve_out <= LTC_RES_HIGH;
      first_beam_level <= LTC_LEVEL_NONE;
      last_beam_level <= LTC_LEVEL_NONE;
    end else begin
      regulate_strobe <= 1'b0;
      store_nvm <= 1'b0;
      store_volatile <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (teach_req) begin // R9
            state_reg <= ST_CHECK;
            waiting <= 1'b1; // R17
          end
        end
        ST_CHECK: begin
          state_reg <= ST_DONE;
          if (!(&(beam_in_corridor | beam_blocked)) || // R7
              (areas == 3'h0 && |beam_blocked) || // R13
              (areas != 3'h0 && blank_fail)) begin
            teach_err <= 1'b1;
            first_beam_level <= LTC_LEVEL_NONE; // R19
            last_beam_level <= LTC_LEVEL_NONE; // R19
          end else begin
            teach_err <= 1'b0;
            beam_suppress <= (areas == 3'h0) ? '0 : widened; // R14
            reserve_out <= ctrl_reg[LTC_CTRL_RES_LO +: 2]; // R7
            regulate_strobe <= 1'b1; // R7
            store_nvm <= ctrl_reg[LTC_CTRL_NVM]; // R8
            store_volatile <= !ctrl_reg[LTC_CTRL_NVM]; // R8
            first_beam_level <= LTC_LEVEL_MAX; // R18
            last_beam_level <= LTC_LEVEL_MAX; // R18
          end
        end
        ST_DONE: begin
          waiting <= 1'b0; // R17
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
          waiting <= 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // Measurement reporting, frozen in alignment operation
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      interrupted_beam_count <= 8'h00;
      configurable_lines <= 4'h0;
    end else if (measure_mode) begin
      interrupted_beam_count <= 8'(pop(beam_blocked)); // R12
      configurable_lines <= line_states; // R12
    end
  end

  // ============================================================
  // Read port
  ltc_status_t st;
  assign st = '{waiting: waiting, teach_ok: !teach_err && |first_beam_level,
                teach_err: teach_err, measure_mode: measure_mode};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_rdata <= LTC_RD_ZERO;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        LTC_ADDR_CTRL: bus_rdata <= {24'h000000, ctrl_reg};
        LTC_ADDR_STATUS: bus_rdata <= {28'h0000000, st};
        LTC_ADDR_COUNT: bus_rdata <= {20'h00000, configurable_lines,
                                      interrupted_beam_count};
        LTC_ADDR_LEVELS: bus_rdata <= {16'h0000, last_beam_level,
                                       first_beam_level};
        LTC_ADDR_BLANK: bus_rdata <= 32'(beam_suppress);
        default: bus_rdata <= LTC_RD_ZERO;
      endcase
    end else begin
      bus_rdata <= LTC_RD_ZERO;
    end
  end
endmodule : ltc_teach_ctrl

/* tb.sv */
// Self-checking bench for the teach and mode controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ltc_pkg::*;
  typedef struct {
    int src;
    logic [7:0] ctrl, cor, blk, sup;
    logic err;
  } ltc_row_t;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  ltc_bus_req_t bus_req = '0;
  logic panel_teach = 1'b0;
  logic fieldbus_teach = 1'b0;
  logic config_teach = 1'b0;
  logic [7:0] beam_blocked = '0;
  logic [7:0] beam_in_corridor = '1;
  logic [3:0] line_states = 4'ha;
  logic npn = 1'b0;
  logic teach_line, regulate_strobe, store_nvm, store_volatile, waiting;
  logic measure_mode, teach_err;
  logic [31:0] bus_rdata, rd_v;
  logic [7:0] beam_suppress, first_beam_level, last_beam_level;
  logic [7:0] interrupted_beam_count;
  logic [3:0] configurable_lines;
  logic [1:0] reserve_out;
  int error_cnt = 0, comparisons = 0, teaches = 0, nt = 0, vol = 0, nv = 0;
  int plen[4] = '{20, 21, 79, 80};
  // Sources 0..2 are the request strobes, 3 a command write
  ltc_row_t rows[8] = '{
    '{0, 8'h04, 8'hff, 8'h00, 8'h00, 1'b0},
    '{1, 8'h05, 8'hff, 8'h00, 8'h00, 1'b0},
    '{2, 8'h06, 8'hff, 8'h10, 8'h00, 1'b1},
    '{3, 8'h03, 8'hff, 8'h00, 8'h00, 1'b0},
    '{0, 8'h04, 8'hfe, 8'h00, 8'h00, 1'b1},
    '{1, 8'h24, 8'hff, 8'h08, 8'h1c, 1'b0},
    '{2, 8'h24, 8'hff, 8'h1e, 8'h00, 1'b1},
    '{3, 8'h24, 8'hff, 8'h41, 8'h00, 1'b1}};

  always #5 clk_sys = ~clk_sys;
  always @(posedge waiting) teaches++;
  always @(posedge clk_sys) if (store_volatile === 1'b1) vol++;
  always @(posedge clk_sys) if (store_nvm === 1'b1) nv++;
  ltc_teach_ctrl #(.BEAMS(8), .MIN_CYC(20), .MAX_CYC(80))
    i_ltc_teach_ctrl (.*);
  ltc_plc_model i_ltc_plc_model (.clk_sys(clk_sys), .npn(npn),
    .teach_line(teach_line));

  // ============================================================
  // Tasks
  task automatic cmp(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // One idle edge after each access keeps strobes single-driven
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, d, w, !w};
    @(posedge clk_sys);
    bus_req <= '0;
    @(negedge clk_sys);
    rd_v = bus_rdata;
    @(posedge clk_sys);
  endtask : bus
  task automatic req(input int s);
    @(posedge clk_sys);
    case (s)
      0: panel_teach <= 1'b1;
      1: fieldbus_teach <= 1'b1;
      2: config_teach <= 1'b1;
      default: bus_req <= '{LTC_ADDR_CMD, 32'h1, 1'b1, 1'b0};
    endcase
    @(posedge clk_sys);
    {panel_teach, fieldbus_teach, config_teach} <= 3'h0;
    bus_req <= '0;
    repeat (6) @(posedge clk_sys);
  endtask : req
  task automatic res(input logic e, input logic acc);
    nt += acc;
    cmp("teach_err", e, teach_err);
    cmp("first_level", e ? 8'h00 : 8'hff, first_beam_level);
    cmp("last_level", e ? 8'h00 : 8'hff, last_beam_level);
    cmp("teaches", nt, teaches);
  endtask : res
  task automatic print_verdict;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  initial begin
    #100us;
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    bus(1'b0, LTC_ADDR_CTRL, 32'h0);
    cmp("ctrl", 32'h4, rd_v);
    cmp("mode", 1'b0, measure_mode);
    bus(1'b0, 8'h20, 32'h0);
    cmp("unmapped", 32'h0, rd_v);
    foreach (rows[i]) begin
      bus(1'b1, LTC_ADDR_CTRL, {24'h0, rows[i].ctrl});
      beam_blocked <= rows[i].blk;
      beam_in_corridor <= rows[i].cor;
      req(rows[i].src);
      res(rows[i].err, 1'b1);
      if (!rows[i].err) begin
        cmp("reserve", rows[i].ctrl[1:0], reserve_out);
        cmp("suppress", rows[i].sup, beam_suppress);
      end
    end
    cmp("volatile", 1, vol);
    cmp("nvm", 3, nv);
    bus(1'b1, LTC_ADDR_CMD, 32'h2);
    beam_blocked <= 8'h05;
    repeat (3) @(posedge clk_sys);
    cmp("mode", 1'b1, measure_mode);
    cmp("count", 8'h02, interrupted_beam_count);
    cmp("lines", 4'ha, configurable_lines);
    bus(1'b1, LTC_ADDR_CTRL, 32'h4);
    beam_blocked <= 8'h00;
    req(0);
    res(1'b0, 1'b1);
    cmp("mode", 1'b1, measure_mode);
    bus(1'b0, LTC_ADDR_STATUS, 32'h0);
    cmp("status", 32'h5, rd_v);
    bus(1'b0, LTC_ADDR_LEVELS, 32'h0);
    cmp("levels", 32'hffff, rd_v);
    bus(1'b0, LTC_ADDR_COUNT, 32'h0);
    cmp("count_reg", 32'h0a00, rd_v);
    bus(1'b1, LTC_ADDR_CMD, 32'h4);
    @(posedge clk_sys);
    cmp("mode", 1'b0, measure_mode);
    for (int p = 0; p < 2; p++) begin
      npn <= p[0];
      bus(1'b1, LTC_ADDR_CTRL, p ? 32'h1c : 32'h14);
      repeat (4) @(posedge clk_sys);
      foreach (plen[i]) begin
        i_ltc_plc_model.pulse(plen[i]);
        repeat (8) @(posedge clk_sys);
        res(1'b0, plen[i] > 20 && plen[i] < 80);
      end
    end
    bus(1'b1, LTC_ADDR_CTRL, 32'h0c);
    i_ltc_plc_model.pulse(50);
    repeat (8) @(posedge clk_sys);
    res(1'b0, 1'b0);
    // Mid-run reset from measurement operation
    bus(1'b1, LTC_ADDR_CMD, 32'h2);
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    cmp("mode", 1'b0, measure_mode);
    bus(1'b0, LTC_ADDR_CTRL, 32'h0);
    cmp("ctrl", 32'h4, rd_v);
    print_verdict();
  end
endmodule : tb
